// >>> ccmx_pkg.sv
/*
 package for the cic/mixer/nco channel control block: register offsets,
 field positions, reset values and decoded control carriers.
 assumes a 16-bit register word reached over a plain strobe port.
*/
package ccmx_pkg;
	localparam int ADDR_W = 5;
	localparam int DATA_W = 16;
	localparam logic [4:0] OFF_CIC_MODE  = 5'h10;
	localparam logic [4:0] OFF_PHASE     = 5'h11;
	localparam logic [4:0] OFF_FREQ_LO   = 5'h12;
	localparam logic [4:0] OFF_FREQ_MID  = 5'h13;
	localparam logic [4:0] OFF_FREQ_HI   = 5'h14;
	localparam logic [4:0] OFF_MIXER     = 5'h15;
	localparam logic [4:0] OFF_NCO_SYNC  = 5'h16;
	localparam logic [4:0] OFF_CIC_COUNT = 5'h17;
	localparam logic [4:0] OFF_CHAN_SYNC = 5'h18;
	localparam logic [4:0] OFF_FREQ_ALL  = 5'h19;
	localparam logic [15:0] RST_CHAN_SYNC = 16'h4FB2;
	localparam logic [15:0] RST_NCO_SYNC  = 16'h0036;
	localparam logic [15:0] RST_CIC_COUNT = 16'h2000;
	localparam logic [15:0] RST_ZERO      = 16'h0000;
	localparam int SYNC_W = 3;
	localparam int SH_LO = 0;
	localparam int SH_HI = 5;
	localparam logic [5:0] SHIFT_MAX = 6'h27;
	localparam int MODE_LO = 6;
	localparam int B_5STG = 8;
	localparam int B_RUP = 9;
	localparam int B_2X = 10;
	localparam int B_D6 = 11;
	localparam int B_CROSS = 12;
	localparam int B_FULL = 13;
	localparam int B_BYP = 14;
	localparam int B_FLUSH = 15;
	localparam int F_FIR = 0;
	localparam int F_COEF = 3;
	localparam int F_GAIN = 6;
	localparam int F_PWR = 9;
	localparam int F_SCK = 12;
	localparam int F_FREQ = 0;
	localparam int F_PHASE = 3;
	localparam int F_DITH = 6;
	localparam int F_NCO = 9;
	localparam int F_FLSH = 12;
	localparam int F_CICS = 12;
	localparam int NCIC_W = 12;
	localparam int MIX_SEL_LO = 0;
	localparam int MIX_CMPLX = 2;
	localparam int MIX_QSIN = 5;
	localparam int MIX_QCOS = 8;
	localparam int MIX_ISIN = 11;
	localparam int MIX_ICOS = 14;
	localparam logic [2:0] STG_NORMAL = 3'h6;
	localparam logic [2:0] STG_FIVE = 3'h5;

	typedef enum logic [1:0] {CCMX_QUIET, CCMX_RCV, CCMX_XMT, CCMX_ILLEGAL} ccmx_mode_t;
	typedef enum logic [1:0] {CCMX_D_ZERO, CCMX_D_RCV, CCMX_D_XCROSS, CCMX_D_XMT} ccmx_dsel_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              wr;
		logic              rd;
	} ccmx_bus_t;

	typedef struct packed {
		ccmx_mode_t mode;
		logic [2:0] stages;
		logic [5:0] shift;
		logic       rcv_upshift;
		logic       double_rate;
		logic       double_six;
		logic       cross_strap;
		logic       sat_full;
		logic       bypass;
		logic [NCIC_W-1:0] ratio_m1;
		logic [3:0] mul_invert;
		ccmx_dsel_t [3:0] mul_src;
		logic [1:0] rcv_path;
		logic       rcv_complex;
	} ccmx_cfg_t;
endpackage

// >>> ccmx_channel_control.sv
/*
 control block for one channel's cic filter, mixer and nco: register file,
 sync source gating of word updates and decoded controls to the datapath.
 assumes sync_events is an 8-bit vector on the core clock, one bit per
 sync source code, and flush_done a core-clock pulse from the cic.
*/
`timescale 1ns/1ps
// Operation
// - fir resync source field, default 2
// - coefficient swap source field, default 6
// - gain update source field, default 6
// - power meter start source, default 7
// - slow clock divider source, default 4
// - cic gain shifter, 0 to 39
// - cic mode quiet, receive, transmit, illegal
// - transmit five stages when bit set
// - receive upshift one bit before rounding
// - double rate; six-stage double-rate flag
// - cross-strapped receive input for b/d
// - receive saturation full or half scale
// - bypass cic in transmit only
// - sticky autoflush flag, software clears
// - tuning word from three words, combined
// - receive mixer path and complex select
// - per-multiplier data source selection
// - per-multiplier product invert bits
// - frequency and phase apply on sync
// - nco update and flush on sync
// - cic ratio minus one and counter sync
module ccmx_channel_control
	import ccmx_pkg::*;
#(
	parameter int NUM_SRC = 8
)
(
	input  wire logic              clock,
	input  wire logic              rst_n,
	input  wire ccmx_bus_t         bus,
	output logic [DATA_W-1:0]      rdata,
	input  wire logic [NUM_SRC-1:0] sync_events,
	input  wire logic              flush_done,
	output ccmx_cfg_t              cfg,
	output logic [47:0]            tuning_word,
	output logic [15:0]            phase_word,
	output logic                   fir_sync,
	output logic                   coef_sync,
	output logic                   gain_sync,
	output logic                   pwr_sync,
	output logic                   sck_sync,
	output logic                   cic_count_sync,
	output logic                   nco_update,
	output logic                   cic_flush,
	output logic                   dither_sync
);
	typedef struct packed {
		logic [15:0] mode;
		logic [15:0] phase;
		logic [47:0] freq;
		logic [15:0] mixer;
		logic [15:0] nco_sync;
		logic [15:0] cic_count;
		logic [15:0] chan_sync;
		logic [47:0] freq_act;
		logic [15:0] phase_act;
		logic [15:0] rdata;
		logic [8:0]  pulses;
	} ccmx_state_t;

	ccmx_state_t st_reg;
	ccmx_state_t st_next;

	// source count must match the code width
	if (NUM_SRC != (1 << SYNC_W)) begin : g_src_check
		$error("sync source count must match the code width");
	end

	// one shared code space
	// common source decode
	function automatic logic pick(input logic [15:0] w, input int lo,
		input logic [NUM_SRC-1:0] ev);
		logic [2:0] code;
		code = w[lo +: SYNC_W];
		pick = ev[code];
	endfunction

	logic [NUM_SRC-1:0] ev;
	assign ev = sync_events;

	always_comb begin
		st_next = st_reg;
		// sticky flag, set wins
		if (bus.wr && bus.addr == OFF_CIC_MODE) begin
			st_next.mode = bus.wdata;
			st_next.mode[B_FLUSH] = st_reg.mode[B_FLUSH] & bus.wdata[B_FLUSH];
		end
		if (flush_done) begin
			st_next.mode[B_FLUSH] = 1'b1;
		end
		if (bus.wr) begin
			case (bus.addr)
				OFF_PHASE:     st_next.phase = bus.wdata;
				OFF_FREQ_LO:   st_next.freq[15:0] = bus.wdata;
				OFF_FREQ_MID:  st_next.freq[31:16] = bus.wdata;
				OFF_FREQ_HI:   st_next.freq[47:32] = bus.wdata;
				OFF_FREQ_ALL:  st_next.freq = {bus.wdata, bus.wdata, bus.wdata};
				OFF_MIXER:     st_next.mixer = bus.wdata;
				OFF_NCO_SYNC:  st_next.nco_sync = bus.wdata;
				OFF_CIC_COUNT: st_next.cic_count = bus.wdata;
				OFF_CHAN_SYNC: st_next.chan_sync = bus.wdata;
				default: begin
				end
			endcase
		end
		if (pick(st_reg.nco_sync, F_FREQ, ev)) begin
			st_next.freq_act = st_reg.freq;
		end
		if (pick(st_reg.nco_sync, F_PHASE, ev)) begin
			st_next.phase_act = st_reg.phase;
		end
		st_next.pulses[0] = pick(st_reg.chan_sync, F_FIR, ev);
		st_next.pulses[1] = pick(st_reg.chan_sync, F_COEF, ev);
		st_next.pulses[2] = pick(st_reg.chan_sync, F_GAIN, ev);
		st_next.pulses[3] = pick(st_reg.chan_sync, F_PWR, ev);
		st_next.pulses[4] = pick(st_reg.chan_sync, F_SCK, ev);
		st_next.pulses[5] = pick(st_reg.cic_count, F_CICS, ev);
		st_next.pulses[6] = pick(st_reg.nco_sync, F_NCO, ev);
		st_next.pulses[7] = pick(st_reg.nco_sync, F_FLSH, ev);
		st_next.pulses[8] = pick(st_reg.nco_sync, F_DITH, ev);
		st_next.rdata = RST_ZERO;
		if (bus.rd) begin
			case (bus.addr)
				OFF_CIC_MODE:  st_next.rdata = st_reg.mode;
				OFF_PHASE:     st_next.rdata = st_reg.phase;
				OFF_FREQ_LO:   st_next.rdata = st_reg.freq[15:0];
				OFF_FREQ_MID:  st_next.rdata = st_reg.freq[31:16];
				OFF_FREQ_HI:   st_next.rdata = st_reg.freq[47:32];
				OFF_MIXER:     st_next.rdata = st_reg.mixer;
				OFF_NCO_SYNC:  st_next.rdata = st_reg.nco_sync;
				OFF_CIC_COUNT: st_next.rdata = st_reg.cic_count;
				OFF_CHAN_SYNC: st_next.rdata = st_reg.chan_sync;
				default:       st_next.rdata = RST_ZERO;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			st_reg           <= '0;
			st_reg.nco_sync  <= RST_NCO_SYNC;
			st_reg.cic_count <= RST_CIC_COUNT;
			st_reg.chan_sync <= RST_CHAN_SYNC;
		end else begin
			st_reg <= st_next;
		end
	end

	assign rdata          = st_reg.rdata;
	assign tuning_word    = st_reg.freq_act;
	assign phase_word     = st_reg.phase_act;
	assign fir_sync       = st_reg.pulses[0];
	assign coef_sync      = st_reg.pulses[1];
	assign gain_sync      = st_reg.pulses[2];
	assign pwr_sync       = st_reg.pulses[3];
	assign sck_sync       = st_reg.pulses[4];
	assign cic_count_sync = st_reg.pulses[5];
	assign nco_update     = st_reg.pulses[6];
	assign cic_flush      = st_reg.pulses[7];
	assign dither_sync    = st_reg.pulses[8];

	ccmx_mode_t mode_dec;
	assign mode_dec = ccmx_mode_t'(st_reg.mode[MODE_LO +: 2]);

	always_comb begin
		cfg = '0;
		cfg.mode = mode_dec;
		cfg.shift = (st_reg.mode[SH_HI:SH_LO] > SHIFT_MAX) ? SHIFT_MAX
			: st_reg.mode[SH_HI:SH_LO];
		cfg.stages = (mode_dec == CCMX_XMT && st_reg.mode[B_5STG]) ? STG_FIVE : STG_NORMAL;
		cfg.rcv_upshift = (mode_dec == CCMX_RCV) & st_reg.mode[B_RUP];
		cfg.double_rate = st_reg.mode[B_2X];
		cfg.double_six = st_reg.mode[B_D6];
		cfg.cross_strap = (mode_dec == CCMX_RCV) & st_reg.mode[B_CROSS];
		cfg.sat_full = (mode_dec == CCMX_RCV) & st_reg.mode[B_FULL];
		cfg.bypass = (mode_dec == CCMX_XMT) & st_reg.mode[B_BYP];
		cfg.ratio_m1 = st_reg.cic_count[NCIC_W-1:0];
		cfg.rcv_path = st_reg.mixer[MIX_SEL_LO +: 2];
		cfg.rcv_complex = st_reg.mixer[MIX_CMPLX];
		cfg.mul_src[0] = ccmx_dsel_t'(st_reg.mixer[MIX_QSIN +: 2]);
		cfg.mul_src[1] = ccmx_dsel_t'(st_reg.mixer[MIX_QCOS +: 2]);
		cfg.mul_src[2] = ccmx_dsel_t'(st_reg.mixer[MIX_ISIN +: 2]);
		cfg.mul_src[3] = ccmx_dsel_t'(st_reg.mixer[MIX_ICOS +: 2]);
		cfg.mul_invert[0] = st_reg.mixer[MIX_QSIN-1];
		cfg.mul_invert[1] = st_reg.mixer[MIX_QCOS-1];
		cfg.mul_invert[2] = st_reg.mixer[MIX_ISIN-1];
		cfg.mul_invert[3] = st_reg.mixer[MIX_ICOS-1];
	end

	property p_flush_sticky;
		@(posedge clock) disable iff (!rst_n) flush_done |=> st_reg.mode[B_FLUSH];
	endproperty
	a_flush_sticky: assert property (p_flush_sticky) else $error("flush flag not set");

	property p_freq_sync;
		@(posedge clock) disable iff (!rst_n)
			ev[st_reg.nco_sync[F_FREQ +: SYNC_W]] |=> tuning_word == $past(st_reg.freq);
	endproperty
	a_freq_sync: assert property (p_freq_sync) else $error("tuning word not applied");

	property p_freq_hold;
		@(posedge clock) disable iff (!rst_n)
			!ev[st_reg.nco_sync[F_FREQ +: SYNC_W]] |=> $stable(tuning_word);
	endproperty
	a_freq_hold: assert property (p_freq_hold) else $error("tuning word moved early");

	property p_shift;
		@(posedge clock) disable iff (!rst_n) cfg.shift <= SHIFT_MAX;
	endproperty
	a_shift: assert property (p_shift) else $error("shift above range");

	property p_stage;
		@(posedge clock) disable iff (!rst_n) (cfg.stages == STG_FIVE) |-> mode_dec == CCMX_XMT;
	endproperty
	a_stage: assert property (p_stage) else $error("five stages outside transmit");

	property p_bypass;
		@(posedge clock) disable iff (!rst_n) cfg.bypass |-> mode_dec == CCMX_XMT;
	endproperty
	a_bypass: assert property (p_bypass) else $error("bypass outside transmit");

	property p_fir;
		@(posedge clock) disable iff (!rst_n)
			ev[st_reg.chan_sync[F_FIR +: SYNC_W]] && !(bus.wr && bus.addr == OFF_CHAN_SYNC)
			|=> fir_sync;
	endproperty
	a_fir: assert property (p_fir) else $error("fir sync missed");

	property p_flush_sync;
		@(posedge clock) disable iff (!rst_n)
			ev[st_reg.nco_sync[F_FLSH +: SYNC_W]] && !(bus.wr && bus.addr == OFF_NCO_SYNC)
			|=> cic_flush;
	endproperty
	a_flush_sync: assert property (p_flush_sync) else $error("flush sync missed");

	property p_phase_sync;
		@(posedge clock) disable iff (!rst_n)
			ev[st_reg.nco_sync[F_PHASE +: SYNC_W]] |=> phase_word == $past(st_reg.phase);
	endproperty
	a_phase_sync: assert property (p_phase_sync) else $error("phase not applied");

	property p_phase_hold;
		@(posedge clock) disable iff (!rst_n)
			!ev[st_reg.nco_sync[F_PHASE +: SYNC_W]] |=> $stable(phase_word);
	endproperty
	a_phase_hold: assert property (p_phase_hold) else $error("phase moved early");

	property p_coef;
		@(posedge clock) disable iff (!rst_n)
			ev[st_reg.chan_sync[F_COEF +: SYNC_W]] |=> coef_sync;
	endproperty
	a_coef: assert property (p_coef) else $error("coefficient sync missed");

	property p_gain;
		@(posedge clock) disable iff (!rst_n)
			ev[st_reg.chan_sync[F_GAIN +: SYNC_W]] |=> gain_sync;
	endproperty
	a_gain: assert property (p_gain) else $error("gain sync missed");

	property p_pwr;
		@(posedge clock) disable iff (!rst_n)
			ev[st_reg.chan_sync[F_PWR +: SYNC_W]] |=> pwr_sync;
	endproperty
	a_pwr: assert property (p_pwr) else $error("power meter sync missed");

	property p_sck;
		@(posedge clock) disable iff (!rst_n)
			ev[st_reg.chan_sync[F_SCK +: SYNC_W]] |=> sck_sync;
	endproperty
	a_sck: assert property (p_sck) else $error("divider sync missed");

	property p_cic_cnt;
		@(posedge clock) disable iff (!rst_n)
			ev[st_reg.cic_count[F_CICS +: SYNC_W]] |=> cic_count_sync;
	endproperty
	a_cic_cnt: assert property (p_cic_cnt) else $error("counter sync missed");

	property p_nco_upd;
		@(posedge clock) disable iff (!rst_n)
			ev[st_reg.nco_sync[F_NCO +: SYNC_W]] |=> nco_update;
	endproperty
	a_nco_upd: assert property (p_nco_upd) else $error("nco update missed");

	property p_dither;
		@(posedge clock) disable iff (!rst_n)
			ev[st_reg.nco_sync[F_DITH +: SYNC_W]] |=> dither_sync;
	endproperty
	a_dither: assert property (p_dither) else $error("dither sync missed");

	property p_fir_only;
		@(posedge clock) disable iff (!rst_n)
			fir_sync |-> $past(ev[st_reg.chan_sync[F_FIR +: SYNC_W]]);
	endproperty
	a_fir_only: assert property (p_fir_only) else $error("spurious fir sync");

	sequence s_flag_clear;
		bus.wr && bus.addr == OFF_CIC_MODE && !bus.wdata[B_FLUSH] && !flush_done;
	endsequence
	property p_flush_clear;
		@(posedge clock) disable iff (!rst_n) s_flag_clear |=> !st_reg.mode[B_FLUSH];
	endproperty
	a_flush_clear: assert property (p_flush_clear) else $error("flag not cleared");

	sequence s_flag_held;
		st_reg.mode[B_FLUSH] && !(bus.wr && bus.addr == OFF_CIC_MODE && !bus.wdata[B_FLUSH]);
	endsequence
	property p_flush_keep;
		@(posedge clock) disable iff (!rst_n) s_flag_held |=> st_reg.mode[B_FLUSH];
	endproperty
	a_flush_keep: assert property (p_flush_keep) else $error("flag dropped");

	property p_flush_rise;
		@(posedge clock) disable iff (!rst_n)
			$rose(st_reg.mode[B_FLUSH]) |-> $past(flush_done);
	endproperty
	a_flush_rise: assert property (p_flush_rise) else $error("flag set by write");

	property p_freq_all;
		@(posedge clock) disable iff (!rst_n)
			bus.wr && bus.addr == OFF_FREQ_ALL |=> st_reg.freq == {3{$past(bus.wdata)}};
	endproperty
	a_freq_all: assert property (p_freq_all) else $error("combined write lost");

	property p_upshift;
		@(posedge clock) disable iff (!rst_n)
			mode_dec == CCMX_RCV && st_reg.mode[B_RUP] |-> cfg.rcv_upshift;
	endproperty
	a_upshift: assert property (p_upshift) else $error("upshift not applied");

	property p_sat;
		@(posedge clock) disable iff (!rst_n)
			cfg.sat_full |-> mode_dec == CCMX_RCV && st_reg.mode[B_FULL];
	endproperty
	a_sat: assert property (p_sat) else $error("saturation outside receive");

endmodule // ccmx_channel_control

// >>> ccmx_channel_control_tb.sv
/*
 self-checking bench for the channel control block: register file,
 sticky flush flag, sync source gating and decoded controls.
 assumes the package constants and a single 200 MHz core clock.
*/
`timescale 1ns/1ps
module ccmx_channel_control_tb;
	import ccmx_pkg::*;
	logic              clock;
	logic              rst_n;
	ccmx_bus_t         bus;
	logic [DATA_W-1:0] rdata;
	logic [7:0]        sync_events;
	logic              flush_done;
	ccmx_cfg_t         cfg;
	logic [47:0]       tuning_word;
	logic [15:0]       phase_word;
	logic              fir_sync, coef_sync, gain_sync, pwr_sync, sck_sync;
	logic              cic_count_sync, nco_update, cic_flush, dither_sync;
	logic [15:0]       sh [0:31];
	logic [15:0]       exp_q [$];
	logic              rd_seen;
	logic [47:0]       exp_tw;
	logic [15:0]       exp_ph, w;
	int                mismatches, comparisons;

	ccmx_channel_control u_ccmx_channel_control (.clock(clock), .rst_n(rst_n), .bus(bus),
		.rdata(rdata), .sync_events(sync_events), .flush_done(flush_done), .cfg(cfg),
		.tuning_word(tuning_word), .phase_word(phase_word), .fir_sync(fir_sync),
		.coef_sync(coef_sync), .gain_sync(gain_sync), .pwr_sync(pwr_sync),
		.sck_sync(sck_sync), .cic_count_sync(cic_count_sync), .nco_update(nco_update),
		.cic_flush(cic_flush), .dither_sync(dither_sync));

	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end

	task automatic check(input logic [47:0] seen, input logic [47:0] expv);
		comparisons++;
		if (seen !== expv) begin
			mismatches++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, expv);
		end
	endtask

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic issue(input logic [4:0] a, input logic [15:0] d, input logic wr, input logic rd);
		bus <= '{addr: a, wdata: d, wr: wr, rd: rd};
		@(posedge clock);
	endtask

	task automatic idle();
		bus <= '0;
		@(posedge clock);
	endtask

	task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
		issue(a, d, 1'b1, 1'b0);
		if (a == OFF_FREQ_ALL) begin
			sh[18] = d;
			sh[19] = d;
			sh[20] = d;
		end else if (a == OFF_CIC_MODE)
			sh[16] = {sh[16][15] & d[15], d[14:0]};
		else if (a >= OFF_CIC_MODE && a <= OFF_CHAN_SYNC)
			sh[a] = d;
	endtask

	task automatic rd_reg(input logic [4:0] a);
		exp_q.push_back(sh[a]);
		issue(a, 16'h0000, 1'b0, 1'b1);
	endtask

	// read data compared in the cycle after the read strobe
	always @(posedge clock) begin
		if (rd_seen)
			check(rdata, exp_q.pop_front());
		rd_seen <= bus.rd;
	end

	task automatic sweep();
		for (int k = 0; k < 8; k++) begin
			sync_events <= 8'h01 << k;
			@(posedge clock);
			sync_events <= 8'h00;
			if (sh[22][2:0] == k) exp_tw = {sh[20], sh[19], sh[18]};
			if (sh[22][5:3] == k) exp_ph = sh[17];
			#1;
			check(fir_sync, sh[24][2:0] == k);
			check(coef_sync, sh[24][5:3] == k);
			check(gain_sync, sh[24][8:6] == k);
			check(pwr_sync, sh[24][11:9] == k);
			check(sck_sync, sh[24][14:12] == k);
			check(nco_update, sh[22][11:9] == k);
			check(cic_flush, sh[22][14:12] == k);
			check(cic_count_sync, sh[23][14:12] == k);
			check(dither_sync, sh[22][8:6] == k);
			check(tuning_word, exp_tw);
			check(phase_word, exp_ph);
			@(posedge clock);
		end
		$display("sync sweep done");
	endtask

	initial begin
		for (int i = 0; i < 32; i++) sh[i] = 16'h0000;
		// reset codes: fir 2, coef 6, gain 6, power 7, divider 4, counter 2
		sh[24] = {1'h0, 3'h4, 3'h7, 3'h6, 3'h6, 3'h2};
		sh[22] = {10'h000, 3'h6, 3'h6};
		sh[23] = {1'h0, 3'h2, 12'h000};
		{exp_tw, exp_ph} = '0;
		{bus, sync_events, flush_done, rd_seen} = '0;
		{mismatches, comparisons} = '0;
		rst_n = 1'b0;
		void'($urandom(46716));
		repeat (20) @(posedge clock);
		rst_n <= 1'b1;
		// reset values, unmapped read
		for (int a = 16; a < 25; a++) rd_reg(a[4:0]);
		rd_reg(5'h1F);
		idle();
		$display("reset values done");
		// back to back random writes and readback
		for (int a = 17; a < 25; a++) wr_reg(a[4:0], $urandom());
		wr_reg(5'h1F, $urandom());
		for (int a = 17; a < 25; a++) rd_reg(a[4:0]);
		rd_reg(5'h1F);
		idle();
		#1;
		check(tuning_word, 48'h0);
		check(cfg.ratio_m1, sh[23][11:0]);
		check(cfg.rcv_path, sh[21][1:0]);
		check(cfg.rcv_complex, sh[21][2]);
		for (int j = 0; j < 4; j++) begin
			check(cfg.mul_src[j], sh[21][5 + 3 * j +: 2]);
			check(cfg.mul_invert[j], sh[21][4 + 3 * j]);
		end
		@(posedge clock);
		sweep();
		wr_reg(OFF_FREQ_ALL, $urandom());
		// fir, divider and counter share one source
		w = $urandom();
		w[14:12] = w[2:0];
		wr_reg(OFF_CHAN_SYNC, w);
		wr_reg(OFF_CIC_COUNT, {1'h0, w[2:0], sh[23][11:0]});
		for (int a = 18; a < 21; a++) rd_reg(a[4:0]);
		idle();
		sweep();
		// decoded mode controls for each legal mode
		for (int n = 0; n < 2; n++) begin
			for (int m = 0; m < 3; m++) begin
				w = n ? 16'hFFFF : $urandom();
				w[7:6] = m[1:0];
				w[15] = 1'b0;
				// no bypass in receive, shift 39 with bypass
				if (m == 1) w[14] = 1'b0;
				if (m == 2 && w[14]) w[5:0] = 6'h27;
				// flag set only for double rate six stages
				w[11] = w[10] & ~(m == 2 && w[8]);
				wr_reg(OFF_CIC_MODE, w);
				idle();
				check(cfg.mode, m[1:0]);
				check(cfg.shift, (w[5:0] > 6'h27) ? 6'h27 : w[5:0]);
				check(cfg.stages, (m == 2 && w[8]) ? STG_FIVE : STG_NORMAL);
				check(cfg.rcv_upshift, m == 1 && w[9]);
				check(cfg.double_rate, w[10]);
				check(cfg.double_six, w[11]);
				check(cfg.cross_strap, m == 1 && w[12]);
				check(cfg.sat_full, m == 1 && w[13]);
				check(cfg.bypass, m == 2 && w[14]);
			end
		end
		$display("mode decode done");
		// sticky flush flag: set, kept by a one, cleared by a zero
		flush_done <= 1'b1;
		@(posedge clock);
		flush_done <= 1'b0;
		sh[16][15] = 1'b1;
		@(posedge clock);
		rd_reg(OFF_CIC_MODE);
		wr_reg(OFF_CIC_MODE, sh[16] | 16'h8000);
		rd_reg(OFF_CIC_MODE);
		// flush and clearing write in one cycle: set wins
		flush_done <= 1'b1;
		wr_reg(OFF_CIC_MODE, sh[16] & 16'h7FFF);
		flush_done <= 1'b0;
		sh[16][15] = 1'b1;
		rd_reg(OFF_CIC_MODE);
		wr_reg(OFF_CIC_MODE, sh[16] & 16'h7FFF);
		rd_reg(OFF_CIC_MODE);
		idle();
		idle();
		$display("flush flag done");
		complete_run();
	end

	initial begin
		#(20000 * 5);
		mismatches++;
		complete_run();
	end
endmodule // ccmx_channel_control_tb
